//--- hdl/dcps_sequencer.sv
// Power-on, boot and park sequencer of the display controller
`timescale 1ns/1ns
module dcps_sequencer
    import dcps_pkg::*;
#(
    parameter int unsigned BOOT_CYCLES  = BOOT_CYC,
    parameter int unsigned SETUP_CYCLES = SETUP_CYC,
    parameter int unsigned NPARK_CYCLES = NPARK_CYC
)(
    // Clock, reset, enable
    input  wire logic               i_ref_clk,
    input  wire logic               i_rst_n,
    input  wire logic               i_ce,
    // Pins from host, power manager and companion device
    input  wire logic               i_projector_on_request,
    input  wire logic               i_fast_park_request_low,
    input  wire logic               i_companion_ready,
    input  wire logic               i_core_supply_good,
    // Host attention pin
    output      logic               o_host_attention,
    output      logic               o_host_attention_oe,
    // Status
    output      logic               o_power_on,
    output      logic               o_cmd_ready,
    output      logic               o_park_busy,
    // Companion device
    output      logic               o_companion_reset_n,
    output      dcps_cfg_write_type o_cfg_write
);

    localparam int unsigned SLOT_CYC = SETUP_CYCLES / CFG_WORDS;

    dcps_pins_type  pins_raw;
    dcps_pins_type  pins;
    dcps_state_type state;
    dcps_state_type next_state;
    logic [31:0]    cnt;
    logic [2:0]     cfg_idx;

    assign pins_raw = '{projector_on_request:  i_projector_on_request,
                        fast_park_request_low: i_fast_park_request_low,
                        companion_ready:       i_companion_ready,
                        core_supply_good:      i_core_supply_good};

    dcps_sync u_sync (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_ce      (i_ce),
        .i_pins    (pins_raw),
        .o_pins    (pins)
    );

    always_comb begin
        next_state = state;
        unique case (state)
            st_off: begin
                if (pins.projector_on_request && pins.fast_park_request_low)
                    next_state = st_init;
            end
            st_init: begin
                if (dcps_expired(cnt, BOOT_CYCLES))
                    next_state = st_wait_comp;
            end
            st_wait_comp: begin
                if (pins.companion_ready)
                    next_state = st_setup;
            end
            st_setup: begin
                if (dcps_expired(cnt, SETUP_CYCLES))
                    next_state = st_ready;
            end
            st_ready: begin
                if (!pins.projector_on_request)
                    next_state = st_npark;
            end
            st_npark: begin
                if (dcps_expired(cnt, NPARK_CYCLES))
                    next_state = st_off;
            end
            st_fpark: begin
                if (dcps_expired(cnt, FPARK_CYC))
                    next_state = st_off;
            end
            // Unused code of the 3-bit state falls back to off
            default: next_state = st_off;
        endcase
        // fast park overrides any active phase
        if (!pins.fast_park_request_low && state != st_off &&
            state != st_fpark)
            next_state = st_fpark;
        // Without core power nothing runs
        if (!pins.core_supply_good)
            next_state = st_off;
    end

    // reset release begins from a known state
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n)
            state <= st_off;
        else if (i_ce)
            state <= next_state;
    end

    // Phase timer restarts on every state change
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n)
            cnt <= '0;
        else if (i_ce) begin
            if (next_state != state)
                cnt <= '0;
            else
                cnt <= cnt + 32'h1;
        end
    end

    // Outputs other than the attention enable follow the next state so they change with it
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_host_attention    <= ATTN_RST;
            o_host_attention_oe <= ATTN_OE_RST;
            o_power_on          <= 1'b0;
            o_cmd_ready         <= 1'b0;
            o_park_busy         <= 1'b0;
            o_companion_reset_n <= COMP_RST_N_RST;
        end else if (i_ce) begin
            // attention low only in the ready state
            o_host_attention    <= next_state != st_ready;
            // release the pin without core power
            o_host_attention_oe <= pins.core_supply_good;
            // on mode while any active phase runs
            o_power_on          <= next_state != st_off;
            o_cmd_ready         <= next_state == st_ready;
            o_park_busy         <= next_state == st_npark ||
                                   next_state == st_fpark;
            o_companion_reset_n <= next_state == st_wait_comp ||
                                   next_state == st_setup ||
                                   next_state == st_ready;
        end
    end

    // Startup writes spread evenly over the setup phase
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            cfg_idx     <= '0;
            o_cfg_write <= '0;
        end else if (i_ce) begin
            o_cfg_write.valid <= 1'b0;
            if (state != st_setup)
                cfg_idx <= '0;
            else if (cfg_idx < 3'(CFG_WORDS) &&
                     cnt == 32'(cfg_idx) * 32'(SLOT_CYC)) begin
                o_cfg_write.valid <= 1'b1;
                o_cfg_write.addr  <= CFG_ADDR[cfg_idx[1:0]];
                o_cfg_write.data  <= CFG_DATA[cfg_idx[1:0]];
                cfg_idx           <= cfg_idx + 3'h1;
            end
        end
    end

    chk_on_mode: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (state != st_off) |-> o_power_on)
        else $error("active phase without on mode");

    chk_off_mode: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_ce && state == st_ready && !pins.projector_on_request &&
         pins.fast_park_request_low && pins.core_supply_good)
        |=> state == st_npark ##0 o_cmd_ready == 1'b0)
        else $error("off request did not start normal park");

    chk_attn_release: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (!$past(i_rst_n) && $past(i_ce, 2) == 1'b1 && i_ce)
        |=> o_host_attention)
        else $error("attention not high after reset release");

    chk_ready_flags: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (state == st_ready) |-> !o_host_attention && o_cmd_ready &&
        o_companion_reset_n)
        else $error("ready state without attention low");

    chk_boot_len: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_ce && state == st_init && next_state == st_wait_comp)
        |-> cnt == 32'(BOOT_CYCLES - 1))
        else $error("boot phase length wrong");

    chk_setup_len: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_ce && state == st_setup && next_state == st_ready)
        |-> cnt == 32'(SETUP_CYCLES - 1) && cfg_idx == 3'(CFG_WORDS))
        else $error("setup phase length or write count wrong");

    chk_cmd_gate: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        $rose(o_cmd_ready) |-> $past(state) == st_setup)
        else $error("commands enabled outside setup completion");

    chk_core_hiz: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_ce && !pins.core_supply_good) |=> !o_host_attention_oe)
        else $error("attention driven without core power");

    chk_fast_park: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n || !i_ce)
        (state == st_ready && !pins.fast_park_request_low &&
         pins.core_supply_good)
        |=> state == st_fpark ##0 o_park_busy)
        else $error("fast park not entered");

endmodule

//--- hdl/dcps_pkg.sv
// Package: timing, states and carriers of the display power sequencer
package dcps_pkg;

    // Reference clock, in kHz (50 MHz)
    localparam int unsigned CLK_KHZ       = 50000;

    // Boot time from the on request to initialization done
    localparam int unsigned BOOT_TIME_MS  = 100;
    localparam int unsigned BOOT_CYC      = BOOT_TIME_MS * CLK_KHZ;

    // Companion device setup phase
    localparam int unsigned SETUP_TIME_US = 2750;
    localparam int unsigned SETUP_CYC     = SETUP_TIME_US * CLK_KHZ / 1000;

    // Fast park must finish inside the 32 us the supplies stay good
    localparam int unsigned FPARK_TIME_US = 32;
    localparam int unsigned FPARK_CYC     =
        (FPARK_TIME_US * CLK_KHZ + 999) / 1000;

    // Normal park, within the 20 ms the supplies are held after off
    localparam int unsigned NPARK_TIME_MS = 20;
    localparam int unsigned NPARK_CYC     = NPARK_TIME_MS * CLK_KHZ;

    // Startup values written into the companion device (arbitrary)
    localparam int unsigned CFG_WORDS     = 4;
    localparam logic [3:0][7:0]  CFG_ADDR = {8'h03, 8'h02, 8'h01, 8'h00};
    localparam logic [3:0][15:0] CFG_DATA = {16'h0000, 16'h0001,
                                             16'h0010, 16'h0100};

    // Output values after reset
    localparam logic ATTN_RST             = 1'b1;
    localparam logic ATTN_OE_RST          = 1'b0;
    localparam logic COMP_RST_N_RST       = 1'b0;

    typedef enum logic [2:0] {
        st_off,
        st_init,
        st_wait_comp,
        st_setup,
        st_ready,
        st_npark,
        st_fpark
    } dcps_state_type;

    // Pin inputs from outside the clock domain
    typedef struct packed {
        logic projector_on_request;
        logic fast_park_request_low;
        logic companion_ready;
        logic core_supply_good;
    } dcps_pins_type;

    // One register write towards the companion device
    typedef struct packed {
        logic        valid;
        logic [7:0]  addr;
        logic [15:0] data;
    } dcps_cfg_write_type;

    // Last cycle of a timed phase
    function automatic logic dcps_expired(input logic [31:0] cnt,
                                          input int unsigned lim);
        return cnt == 32'(lim - 1);
    endfunction

endpackage

//--- hdl/dcps_sync.sv
// Two-flop synchroniser for the sequencer pin inputs
`timescale 1ns/1ns
module dcps_sync
    import dcps_pkg::*;
(
    // Clock, reset, enable
    input  wire logic          i_ref_clk,
    input  wire logic          i_rst_n,
    input  wire logic          i_ce,
    // Pins
    input  wire dcps_pins_type i_pins,
    output      dcps_pins_type o_pins
);

    dcps_pins_type meta;

    // First stage feeds only the second stage
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            meta   <= '0;
            o_pins <= '0;
        end else if (i_ce) begin
            meta   <= i_pins;
            o_pins <= meta;
        end
    end

endmodule

//--- testbench/dcps_partner.sv
// Companion device and power manager model facing the sequencer
`timescale 1ns/1ns
module dcps_partner #(
    parameter int unsigned COMP_DELAY = 25
)(
    // Clock
    input  wire logic i_ref_clk,
    // From sequencer and bench
    input  wire logic i_companion_reset_n,
    input  wire logic i_fault,
    // To sequencer
    output      logic o_companion_ready,
    output      logic o_fast_park_request_low
);
    int unsigned cnt;

    // Ready a fixed time after companion reset release
    always_ff @(posedge i_ref_clk) begin
        if (!i_companion_reset_n) begin
            cnt               <= 0;
            o_companion_ready <= 1'b0;
        end else if (cnt < COMP_DELAY) begin
            cnt <= cnt + 1;
        end else begin
            o_companion_ready <= 1'b1;
        end
    end

    // Held high unless a supply fault is ordered
    always_ff @(posedge i_ref_clk) begin
        o_fast_park_request_low <= !i_fault;
    end
endmodule

//--- testbench/test_display_ctrl_power_sequence.sv
// Self-checking bench of the display power sequencer
`timescale 1ns/1ns
module test_display_ctrl_power_sequence;
    import dcps_pkg::*;
    // Short counts keep the run small
    localparam int BOOT  = 50;
    localparam int SETUP = 40;
    localparam int NPARK = 30;
    localparam int S     = SETUP / 4;
    localparam int B_OE = 0, B_PWR = 2, B_CMD = 3, B_PARK = 4;
    localparam int B_CRST = 5, B_VAL = 6;
    logic               clk       = 1'b0;
    logic               rst_n     = 1'b0;
    logic               on_req    = 1'b0;
    logic               core_good = 1'b1;
    logic               fault     = 1'b0;
    logic               ce        = 1'b1;
    logic               fpark_n;
    logic               comp_ready;
    logic               attn;
    logic               attn_oe;
    logic               pwr_on;
    logic               cmd_rdy;
    logic               park;
    logic               comp_rst_n;
    dcps_cfg_write_type cfg;
    logic [6:0]         st;
    int                 error_cnt = 0;
    int                 n_checks  = 0;

    assign st = {cfg.valid, comp_rst_n, park, cmd_rdy, pwr_on, attn, attn_oe};

    // reference clock runs from time zero
    always #10 clk = ~clk;

    dcps_sequencer #(.BOOT_CYCLES(BOOT), .SETUP_CYCLES(SETUP),
                     .NPARK_CYCLES(NPARK)) dut (
        .i_ref_clk(clk), .i_rst_n(rst_n), .i_ce(ce),
        .i_projector_on_request(on_req), .i_fast_park_request_low(fpark_n),
        .i_companion_ready(comp_ready), .i_core_supply_good(core_good),
        .o_host_attention(attn), .o_host_attention_oe(attn_oe),
        .o_power_on(pwr_on), .o_cmd_ready(cmd_rdy), .o_park_busy(park),
        .o_companion_reset_n(comp_rst_n), .o_cfg_write(cfg));

    dcps_partner partner (
        .i_ref_clk(clk), .i_companion_reset_n(comp_rst_n), .i_fault(fault),
        .o_companion_ready(comp_ready), .o_fast_park_request_low(fpark_n));

    task automatic end_sim();
        if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %0h exp %0h", $time, got, exp);
        end
    endtask

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %0h exp %0h", $time, got, exp);
        end
    endtask

    // Bounded wait for one status bit, n counts the edges taken
    task automatic wait_bit(input int b, input logic v, input int lim,
                            output int n);
        n = 0;
        while (st[b] !== v) begin
            @(posedge clk);
            #1;
            n++;
            if (n > lim) begin
                error_cnt++;
                $display("Error at %0t: got %0h exp %0h", $time, st[b], v);
                end_sim();
            end
        end
    endtask

    task automatic t_reset();
        int n;
        repeat (2) @(posedge clk);
        #1;
        chk_bit(attn, 1'b1);
        chk_bit(attn_oe, 1'b0);
        @(posedge clk);
        rst_n <= 1'b1;
        wait_bit(B_OE, 1'b1, 5, n);
        chk_bit(attn, 1'b1);
        chk_bit(pwr_on, 1'b0);
    endtask

    task automatic t_refuse();
        @(posedge clk);
        fault  <= 1'b1;
        // Park request must be seen before the on request arrives
        repeat (4) @(posedge clk);
        on_req <= 1'b1;
        repeat (8) @(posedge clk);
        #1;
        chk_bit(pwr_on, 1'b0);
    endtask

    task automatic t_boot();
        int n;
        @(posedge clk);
        fault  <= 1'b0;
        on_req <= 1'b1;
        wait_bit(B_PWR, 1'b1, 6, n);
        chk_bit(attn, 1'b1);
        wait_bit(B_CRST, 1'b1, BOOT + 2, n);
        chk_val(n, BOOT);
    endtask

    task automatic t_setup();
        int n;
        wait_bit(B_VAL, 1'b1, 80, n);
        for (int k = 0; k < 4; k++) begin
            if (k > 0) begin
                @(posedge clk);
                #1;
                wait_bit(B_VAL, 1'b1, S, n);
                chk_val(n + 1, S);
            end
            chk_val(32'({cfg.addr, cfg.data}),
                    32'({CFG_ADDR[k], CFG_DATA[k]}));
            chk_bit(cmd_rdy, 1'b0);
        end
        wait_bit(B_CMD, 1'b1, S + 2, n);
        chk_val(n, S - 1);
        chk_bit(attn, 1'b0);
    endtask

    task automatic t_npark();
        int n;
        @(posedge clk);
        on_req <= 1'b0;
        wait_bit(B_PARK, 1'b1, 6, n);
        chk_bit(cmd_rdy, 1'b0);
        chk_bit(attn, 1'b1);
        chk_bit(comp_rst_n, 1'b0);
        // supply kept good through the park
        wait_bit(B_PARK, 1'b0, NPARK + 2, n);
        chk_val(n, NPARK);
        chk_bit(pwr_on, 1'b0);
    endtask

    task automatic t_fpark();
        int n;
        @(posedge clk);
        fault <= 1'b1;
        wait_bit(B_PARK, 1'b1, 6, n);
        chk_bit(cmd_rdy, 1'b0);
        wait_bit(B_PARK, 1'b0, 1602, n);
        chk_val(n, 1600);
        chk_bit(pwr_on, 1'b0);
        @(posedge clk);
        fault <= 1'b0;
    endtask

    // Supply loss in mid boot must release the attention pin
    task automatic t_core();
        int n;
        wait_bit(B_PWR, 1'b1, 10, n);
        @(posedge clk);
        // Supply drops while the enable is low: nothing may move
        ce        <= 1'b0;
        core_good <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
        chk_bit(attn_oe, 1'b1);
        chk_bit(pwr_on, 1'b1);
        @(posedge clk);
        ce <= 1'b1;
        wait_bit(B_OE, 1'b0, 6, n);
        wait_bit(B_PWR, 1'b0, 6, n);
        @(posedge clk);
        on_req    <= 1'b0;
        core_good <= 1'b1;
    endtask

    initial begin
        t_reset();
        t_refuse();
        t_boot();
        t_setup();
        t_npark();
        t_boot();
        t_setup();
        t_fpark();
        t_core();
        end_sim();
    end
endmodule
